// ### verilog/dudc_converter.sv
// down-conversion and up-conversion chains of the converter
// assumes one clock; sample ports and memory streams share ref_clk
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// - The down chain takes five 16-bit real samples per clock as one 80-bit stream word.
// - The down chain accepts every presented input word and never stalls its source.
// - The down mixer multiplies each real sample by a quadrature oscillator, five per clock.
// - The mixer word carries real and imaginary parts of all five lanes, 160 bits.
// - Two real decimate-by-five filters reduce the mixer word to one complex sample per clock.
// - The power-of-two decimator divides the rate by 2^N and passes data when N is zero.
// - The packer gathers 32-bit complex samples, two and a half per word, into 80 bits.
// - Captured data is stored as pairs of real part followed by imaginary part.
// - The up chain hands a new word to the DAC port on every clock.
// - The up chain output is five 16-bit real samples packed in one 80-bit word.
// - The up mixer multiplies complex lanes by the oscillator and keeps the real part.
// - The interpolate-by-five stage makes five filtered complex samples from one.
// - The power-of-two interpolator raises the rate by 2^N and paces input with ready.
module dudc_converter import dudc_pkg::*; #(
  parameter int DEC_LOG2 = 0,
  parameter int INT_LOG2 = 0
) (
  // clock, reset, enable
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  input  wire logic              syncClear,
  // adc sample stream in
  input  wire logic [WIDE_W-1:0] adcData,
  input  wire logic              adcValid,
  output var  logic              adcReady,
  // capture stream out
  output var  logic [WIDE_W-1:0] capData,
  output var  logic              capValid,
  // memory reader stream in
  input  wire logic [CPLX_W-1:0] memData,
  input  wire logic              memValid,
  output var  logic              memReady,
  // dac sample stream out
  output var  logic [WIDE_W-1:0] dacData,
  output var  logic              dacValid
);

  if (DEC_LOG2 < 0 || DEC_LOG2 > P2_MAX_LOG2 ||
      INT_LOG2 < 0 || INT_LOG2 > P2_MAX_LOG2) begin : g_chk
    $error("dudc_converter: power-of-two factor out of range");
  end

  localparam logic [P2_CNT_W-1:0] DEC_LAST =
    P2_CNT_W'((1 << DEC_LOG2) - 1);
  localparam logic [P2_CNT_W-1:0] INT_LAST =
    P2_CNT_W'((1 << INT_LOG2) - 1);

  dudc_top_state_s st;
  dudc_top_state_s next_st;
  dudc_real_t      dnCos;
  dudc_real_t      dnSin;
  dudc_real_t      upCos;
  dudc_real_t      upSin;
  logic            adcTake;

  assign adcTake = ce & adcValid & st.adcRdy;

  // oscillators; down one only moves with accepted words
  dudc_quad_osc #(.STEP(1)) u_dn_osc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clear   (ce & syncClear),
    .advance (adcTake & ~syncClear),
    .cosOut  (dnCos),
    .sinOut  (dnSin)
  );

  dudc_quad_osc #(.STEP(1)) u_up_osc (
    .ref_clk (ref_clk),
    .rstn    (rstn),
    .clear   (ce & syncClear),
    .advance (ce & ~syncClear),
    .cosOut  (upCos),
    .sinOut  (upSin)
  );

  // linear blend between two held samples, k of five steps along
  function automatic logic signed [15:0] blend5(
    input logic signed [15:0] a,
    input logic signed [15:0] b,
    input int                 k);
    logic signed [22:0] w;
    w = 23'(a) * 23'(LANES - k) + 23'(b) * 23'(k);
    return div5(w);
  endfunction

  // whole datapath next state
  always_comb begin
    logic signed [22:0]   sumRe;
    logic signed [22:0]   sumIm;
    logic [P2_ACC_W-1:0]  accRe;
    logic [P2_ACC_W-1:0]  accIm;
    logic [PACK_BUF_W-1:0] pbuf;
    logic [2:0]           fill;
    logic                 memTake;
    sumRe   = '0;
    sumIm   = '0;
    accRe   = '0;
    accIm   = '0;
    pbuf    = st.packBuf;
    fill    = st.packFill;
    memTake = memValid & st.memRdy;
    next_st = st;
    if (ce && syncClear) begin
      // clears everything but keeps both ready flags up
      next_st        = '0;
      next_st.adcRdy = 1'b1;
      next_st.memRdy = 1'b1;
    end else if (ce) begin
      // input is always accepted, nothing upstream waits
      next_st.adcRdy   = 1'b1;
      next_st.mixValid = adcValid & st.adcRdy;
      if (adcValid) begin
        // lane l sits at bits l*16, earliest first
        for (int l = 0; l < LANES; l++) begin
          next_st.mix[l].re =
            mul_q15(adcData[l*SAMP_W +: SAMP_W], dnCos[l]);
          next_st.mix[l].im =
            -mul_q15(adcData[l*SAMP_W +: SAMP_W], dnSin[l]);
        end
      end

      // boxcar low-pass over five lanes then keep one in five
      next_st.d5Valid = st.mixValid;
      if (st.mixValid) begin
        for (int l = 0; l < LANES; l++) begin
          sumRe = sumRe + 23'(st.mix[l].re);
          sumIm = sumIm + 23'(st.mix[l].im);
        end
        next_st.d5.re = div5(sumRe);
        next_st.d5.im = div5(sumIm);
      end

      // average of 2^N samples; N of zero is a plain pass
      next_st.decValid = 1'b0;
      if (st.d5Valid) begin
        accRe = st.p2AccRe + P2_ACC_W'(st.d5.re);
        accIm = st.p2AccIm + P2_ACC_W'(st.d5.im);
        if (st.p2Cnt == DEC_LAST) begin
          next_st.decValid = 1'b1;
          next_st.dec.re   = 16'($signed(accRe) >>> DEC_LOG2);
          next_st.dec.im   = 16'($signed(accIm) >>> DEC_LOG2);
          next_st.p2AccRe  = '0;
          next_st.p2AccIm  = '0;
          next_st.p2Cnt    = '0;
        end else begin
          next_st.p2AccRe = accRe;
          next_st.p2AccIm = accIm;
          next_st.p2Cnt   = st.p2Cnt + P2_CNT_W'(1);
        end
      end

      // packer: append real then imaginary, emit five slots at once
      next_st.capValid = 1'b0;
      if (st.decValid) begin
        pbuf[{fill, 4'h0} +: CPLX_W] = st.dec;
        fill = fill + PACK_IN_SLOTS;
      end
      if (fill >= PACK_OUT_SLOTS) begin
        next_st.capValid = 1'b1;
        next_st.capData  = pbuf[WIDE_W-1:0];
        pbuf = pbuf >> WIDE_W;
        fill = fill - PACK_OUT_SLOTS;
      end
      next_st.packBuf  = pbuf;
      next_st.packFill = fill;

      // hold each fetched sample for 2^N clocks; ready paces the reader
      if (memTake) begin
        next_st.held    = memData;
        next_st.holdCnt = INT_LAST;
      end else if (st.holdCnt != '0) begin
        next_st.holdCnt = st.holdCnt - P2_CNT_W'(1);
      end
      next_st.memRdy   = (next_st.holdCnt == '0);
      next_st.prevHeld = st.held;

      // zero-stuffed five-phase filter reduces to a linear blend
      for (int l = 0; l < LANES; l++) begin
        next_st.i5[l].re = blend5(st.prevHeld.re, st.held.re, l);
        next_st.i5[l].im = blend5(st.prevHeld.im, st.held.im, l);
      end

      // real part of the complex product; the dac never waits
      next_st.dacValid = 1'b1;
      for (int l = 0; l < LANES; l++) begin
        next_st.dacData[l*SAMP_W +: SAMP_W] =
          mul_q15(st.i5[l].re, upCos[l]) -
          mul_q15(st.i5[l].im, upSin[l]);
      end
    end
  end

  // single state register; ready flags come up with reset
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st        <= '0;
      st.adcRdy <= 1'b1;
      st.memRdy <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from state
  assign adcReady = st.adcRdy;
  assign capData  = st.capData;
  assign capValid = st.capValid;
  assign memReady = st.memRdy;
  assign dacData  = st.dacData;
  assign dacValid = st.dacValid;

  // named steps for the checks below
  sequence adcIn;
    ce && adcValid && !syncClear;
  endsequence

  sequence memTakeSeq;
    ce && memValid && memReady && !syncClear;
  endsequence

  adc_always_ready_a: assert property (
    @(posedge ref_clk) disable iff (!rstn) adcReady)
    else $error("adc input was stalled");

  mix_real_lane_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    adcIn |=> st.mixValid && st.mix[0].re ==
      mul_q15($past(adcData[15:0]), $past(dnCos[0])))
    else $error("mixer real lane 0 wrong");

  mix_imag_lane_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    adcIn |=> st.mix[4].im ==
      -mul_q15($past(adcData[79:64]), $past(dnSin[4])))
    else $error("mixer imaginary lane 4 wrong");

  dec5_follows_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    adcIn ##1 (ce && !syncClear) |=> st.d5Valid)
    else $error("decimate-by-five dropped a word");

  decim_pass_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    (DEC_LOG2 == 0) && ce && !syncClear && st.d5Valid |=> st.decValid)
    else $error("power-of-two decimator not passing through");

  pack_emit_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    capValid && $past(ce) && !$past(syncClear) |->
      $past(st.packFill) + ($past(st.decValid) ? 3'h2 : 3'h0) >= 3'h5
      && st.packFill < 3'h5)
    else $error("packer emitted without five slots");

  dac_every_clock_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ce && !syncClear |=> dacValid)
    else $error("dac word missing");

  mem_take_hold_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    memTakeSeq |=> st.held == $past(memData) &&
      (memReady == (INT_LOG2 == 0)))
    else $error("interpolator did not hold fetched sample");

  clear_all_a: assert property (
    @(posedge ref_clk) disable iff (!rstn)
    ce && syncClear |=> !capValid && !dacValid && !st.decValid
      && st.packFill == 3'h0 && st.p2Cnt == '0)
    else $error("clear left state behind");

endmodule // dudc_converter

`default_nettype wire

// ### verilog/dudc_pkg.sv
// constants, types and shared arithmetic for the up/down converter
// assumes one clock domain; all streams are 16-bit signed fixed point
`default_nettype none

package dudc_pkg;

  // stream geometry
  localparam int LANES     = 5;
  localparam int SAMP_W    = 16;
  localparam int WIDE_W    = LANES * SAMP_W;    // 80-bit sample port word
  localparam int CPLX_W    = 2 * SAMP_W;        // one complex sample
  localparam int MIX_W     = LANES * CPLX_W;    // 160-bit mixer word

  // packer geometry, counted in 16-bit slots
  localparam int PACK_SLOTS     = 7;
  localparam int PACK_BUF_W     = PACK_SLOTS * SAMP_W;
  localparam logic [2:0] PACK_OUT_SLOTS = 3'h5;
  localparam logic [2:0] PACK_IN_SLOTS  = 3'h2;
  localparam logic [2:0] PACK_FILL_RST  = 3'h0;

  // power-of-two stages
  localparam int P2_MAX_LOG2 = 7;
  localparam int P2_CNT_W    = 8;
  localparam int P2_ACC_W    = 24;

  // oscillator: four-entry quadrature table, phase in quarter turns
  localparam int OSC_PH_W = 2;
  localparam logic [3:0][15:0] OSC_COS_TAB =
    {16'h0000, 16'h8001, 16'h0000, 16'h7fff};
  localparam logic [3:0][15:0] OSC_SIN_TAB =
    {16'h8001, 16'h0000, 16'h7fff, 16'h0000};
  localparam logic [OSC_PH_W-1:0] OSC_PH_RST = 2'h0;

  // divide by five as multiply by 0x3333 and shift by 16
  localparam logic signed [39:0] DIV5_MUL = 40'sh0000003333;

  typedef struct packed {
    logic signed [15:0] im;
    logic signed [15:0] re;
  } dudc_cplx_s;

  typedef dudc_cplx_s [LANES-1:0] dudc_lanes_t;
  typedef logic [LANES-1:0][15:0] dudc_real_t;

  typedef struct packed {
    logic [OSC_PH_W-1:0] phase;
  } dudc_osc_state_s;

  typedef struct packed {
    logic                  adcRdy;
    logic                  mixValid;
    dudc_lanes_t           mix;
    logic                  d5Valid;
    dudc_cplx_s            d5;
    logic [P2_ACC_W-1:0]   p2AccRe;
    logic [P2_ACC_W-1:0]   p2AccIm;
    logic [P2_CNT_W-1:0]   p2Cnt;
    logic                  decValid;
    dudc_cplx_s            dec;
    logic [PACK_BUF_W-1:0] packBuf;
    logic [2:0]            packFill;
    logic                  capValid;
    logic [WIDE_W-1:0]     capData;
    logic                  memRdy;
    logic [P2_CNT_W-1:0]   holdCnt;
    dudc_cplx_s            held;
    dudc_cplx_s            prevHeld;
    dudc_lanes_t           i5;
    logic                  dacValid;
    logic [WIDE_W-1:0]     dacData;
  } dudc_top_state_s;

  // q15 product, rounded toward minus infinity
  function automatic logic signed [15:0] mul_q15(
    input logic signed [15:0] a,
    input logic signed [15:0] b);
    logic signed [31:0] p;
    p = a * b;
    return p[30:15];
  endfunction

  // approximate division by five
  function automatic logic signed [15:0] div5(
    input logic signed [22:0] x);
    logic signed [39:0] p;
    p = 40'(x) * DIV5_MUL;
    return p[31:16];
  endfunction

endpackage

`default_nettype wire

// ### verilog/dudc_quad_osc.sv
// quadrature oscillator giving cos/sin for five lanes per clock
// assumes advance is already qualified by the clock enable
`timescale 1ns/1ps
`default_nettype none

module dudc_quad_osc import dudc_pkg::*; #(
  parameter int STEP = 1
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rstn,
  // control
  input  wire logic clear,
  input  wire logic advance,
  // oscillator values for the current word
  output var  dudc_real_t cosOut,
  output var  dudc_real_t sinOut
);

  if (STEP < 0 || STEP > 3) begin : g_chk
    $error("dudc_quad_osc: STEP must be 0..3");
  end

  localparam logic [OSC_PH_W-1:0] WORD_STEP = OSC_PH_W'(LANES * STEP);

  dudc_osc_state_s st;
  dudc_osc_state_s next_st;

  // phase moves by one word of lanes per accepted word
  always_comb begin
    next_st = st;
    if (clear) begin
      next_st.phase = OSC_PH_RST;
    end else if (advance) begin
      next_st.phase = st.phase + WORD_STEP;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // per-lane table lookup, lane 0 is the earliest sample
  always_comb begin
    for (int l = 0; l < LANES; l++) begin
      cosOut[l] = OSC_COS_TAB[st.phase + OSC_PH_W'(l * STEP)];
      sinOut[l] = OSC_SIN_TAB[st.phase + OSC_PH_W'(l * STEP)];
    end
  end

endmodule // dudc_quad_osc

`default_nettype wire

// ### tb/dudc_mem_source.sv
// memory reader model feeding the up chain with complex samples
// assumes ready is registered by the converter and sampled on ref_clk
`timescale 1ns/1ps
`default_nettype none

module dudc_mem_source import dudc_pkg::*; (
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              ce,
  // stream to the converter
  input  wire logic              memReady,
  output var  logic              memValid,
  output var  logic [CPLX_W-1:0] memData,
  // statistics
  output var  int                takes
);
  logic [CPLX_W-1:0] cur;

  // offer data only while the converter asks for it
  assign memValid = memReady;
  // released data shows the inverse so stale values never look valid
  assign memData  = memValid ? cur : ~cur;

  // next sample after every accepted take
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      cur   <= 32'h0001_0001;
      takes <= 0;
    end else if (ce && memValid && memReady) begin
      cur   <= cur + 32'h0003_0101;
      takes <= takes + 1;
    end
  end
endmodule // dudc_mem_source

`default_nettype wire

// ### tb/tb_top.sv
// self-checking bench: down chain modelled with integers and queues
// assumes dudc_pkg, the converter and the memory model are compiled
`timescale 1ns/1ps
`default_nettype none

module tb_top import dudc_pkg::*;;
  logic              ref_clk, rstn, ce, syncClear, adcValid, adcReady;
  logic [WIDE_W-1:0] adcData, capData, dacData;
  logic              capValid, memValid, memReady, dacValid;
  logic              capValid2, memValid2, memReady2, dacValid2;
  logic [CPLX_W-1:0] memData, memData2;
  int                takes, takes2, fail_count, n_compared, cyc, runCyc;
  int                mode, ph, cap1, cap2, a, b;
  logic              ceD;
  logic [15:0]       expQ[$];
  logic [CPLX_W-1:0] hs[$];
  int                uph, dph;
  int                cosv[4] = '{32767, 0, -32767, 0};
  int                sinv[4] = '{0, 32767, 0, -32767};

  dudc_converter #(.DEC_LOG2(0), .INT_LOG2(0)) dudc_converter_inst (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .syncClear(syncClear),
    .adcData(adcData), .adcValid(adcValid), .adcReady(adcReady),
    .capData(capData), .capValid(capValid), .memData(memData),
    .memValid(memValid), .memReady(memReady), .dacData(dacData),
    .dacValid(dacValid));
  // second build exercises the power-of-two stages with n above zero
  dudc_converter #(.DEC_LOG2(1), .INT_LOG2(2)) dudc_converter_inst2 (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .syncClear(syncClear),
    .adcData(adcData), .adcValid(adcValid), .adcReady(),
    .capData(), .capValid(capValid2), .memData(memData2),
    .memValid(memValid2), .memReady(memReady2), .dacData(),
    .dacValid(dacValid2));
  dudc_mem_source dudc_mem_source_inst (.ref_clk(ref_clk), .rstn(rstn),
    .ce(ce), .memReady(memReady), .memValid(memValid), .memData(memData),
    .takes(takes));
  dudc_mem_source dudc_mem_source_inst2 (.ref_clk(ref_clk), .rstn(rstn),
    .ce(ce), .memReady(memReady2), .memValid(memValid2),
    .memData(memData2), .takes(takes2));

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // q15 product, low 16 bits of the 15-bit shift
  function automatic logic [15:0] q15(input int x, input int c);
    longint p;
    p = longint'(x) * c;
    return 16'(p >>> 15);
  endfunction

  // linear five-step blend of two held samples, divide as x*13107>>16
  function automatic int blend(input logic [15:0] a, input logic [15:0] b,
                               input int k);
    longint w;
    w = longint'($signed(a)) * (5 - k) + longint'($signed(b)) * k;
    return int'($signed(16'((w * 13107) >>> 16)));
  endfunction

  // dac lane k: blend of samples taken four and three edges back
  function automatic logic [15:0] dac_exp(input int k);
    logic [CPLX_W-1:0] p, c;
    int re, im;
    p = hs[hs.size()-4];
    c = hs[hs.size()-3];
    re = blend(p[15:0], c[15:0], k);
    im = blend(p[31:16], c[31:16], k);
    return 16'($signed(q15(re, cosv[(dph+k)%4]))
               - $signed(q15(im, sinv[(dph+k)%4])));
  endfunction

  // mixer, five-lane boxcar and packer order for one accepted word
  task automatic model_word(input logic [WIDE_W-1:0] w);
    longint sr, si;
    logic [15:0] x;
    sr = 0;
    si = 0;
    for (int l = 0; l < LANES; l++) begin
      x = w[l*SAMP_W +: SAMP_W];
      sr += $signed(q15($signed(x), cosv[(ph+l)%4]));
      si += $signed(16'(-q15($signed(x), sinv[(ph+l)%4])));
    end
    ph = (ph + 5) % 4;
    expQ.push_back(16'((sr * 13107) >>> 16));
    expQ.push_back(16'((si * 13107) >>> 16));
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // reference model and per-cycle port checks
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      expQ.delete();
      ph = 0;
      runCyc = 0;
      ceD = 1'b0;
      hs = '{32'h0, 32'h0, 32'h0};
      uph = 0;
      dph = 0;
    end else begin
      check(16'(adcReady), 16'h1);
      check(16'(memReady), 16'h1);
      if (runCyc >= 2) check(16'(dacValid), 16'h1);
      if (runCyc >= 2) check(16'(dacValid2), 16'h1);
      if (ceD && runCyc >= 2) begin
        for (int k = 0; k < LANES; k++) begin
          check(dacData[k*SAMP_W +: SAMP_W], dac_exp(k));
        end
      end
      if (ceD && capValid === 1'b1) begin
        cap1++;
        for (int s = 0; s < LANES; s++) begin
          if (expQ.size() == 0) check(16'hdead, 16'h0);
          else check(capData[s*SAMP_W +: SAMP_W], expQ.pop_front());
        end
      end
      if (ceD && capValid2 === 1'b1) cap2++;
      if (ce && syncClear) begin
        expQ.delete();
        ph = 0;
        runCyc = 0;
        hs = '{32'h0, 32'h0, 32'h0};
        uph = 0;
        dph = 0;
      end else if (ce) begin
        runCyc++;
        hs.push_back((memValid && memReady) ? memData : hs[$]);
        dph = uph;
        uph = (uph + 1) % 4;
        if (adcValid) model_word(adcData);
      end
      ceD = ce;
    end
  end

  // stimulus: random gaps, or a solid stream for rate checks
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      stop_test();
    end
    if (mode != 0) begin
      adcValid <= (mode == 2) || ($urandom % 4 != 0);
      adcData  <= {$urandom, $urandom, $urandom};
    end else begin
      adcValid <= 1'b0;
      adcData  <= '0;
    end
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b0;
    syncClear = 1'b0;
    mode = 0;
    void'($urandom(32'h4cd2));
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    ce <= 1'b1;
    mode <= 1;
    repeat (300) @(posedge ref_clk);
    $display("test random stream done");
    ce <= 1'b0;
    repeat (20) @(posedge ref_clk);
    ce <= 1'b1;
    $display("test clock enable freeze done");
    repeat (37) @(posedge ref_clk);
    syncClear <= 1'b1;
    @(posedge ref_clk);
    syncClear <= 1'b0;
    repeat (200) @(posedge ref_clk);
    $display("test synchronous clear done");
    mode <= 2;
    repeat (30) @(posedge ref_clk);
    a = cap1;
    b = cap2;
    repeat (100) @(posedge ref_clk);
    check(16'(cap1 - a >= 39 && cap1 - a <= 41), 16'h1);
    check(16'(cap2 - b >= 19 && cap2 - b <= 21), 16'h1);
    a = takes2;
    repeat (80) @(posedge ref_clk);
    check(16'(takes2 - a), 16'd20);
    check(16'(takes > 400), 16'h1);
    $display("test steady rates done");
    stop_test();
  end
endmodule // tb_top

`default_nettype wire
